// >>> kpi_defs.svh
// register offsets, field positions and reset values for the pin interrupt block
// assumes: included by bare name from the design module
`ifndef KPI_DEFS_SVH
`define KPI_DEFS_SVH

// printed offsets are not multiples of four, so they are indices; byte address is index * 4
`define KPI_IDX_STATUS_CONTROL 8'h0c
`define KPI_IDX_PIN_ENABLE 8'h0d
`define KPI_IDX_POLARITY 8'h0e
`define KPI_IDX_IRQ_STATUS 8'h10
`define KPI_IDX_IRQ_MASK 8'h11
`define KPI_IDX_PULL_ENABLE 8'h12

// status and control fields
`define KPI_SC_MODE_BIT 0
`define KPI_SC_REQEN_BIT 1
`define KPI_SC_ACK_BIT 2
`define KPI_SC_FLAG_BIT 3

// reset values
`define KPI_RST_BYTE 8'h00

// axi response codes
`define KPI_RESP_OKAY 2'h0
`define KPI_RESP_SLVERR 2'h2

`endif

// >>> kpi_pkg.sv
// types shared by the pin interrupt block
// assumes: nothing outside
package kpi_pkg;

	typedef logic [7:0] kpi_byte_t;

	// write channel progress of the bus slave
	typedef enum logic [1:0]
	{
		KPI_WR_IDLE,
		KPI_WR_RESP
	} kpi_wr_e;

endpackage

// >>> kpi_pin_interrupt.sv
// pin interrupt module: four external pins, edge or edge-and-level detection,
// one shared event flag acknowledged by software, reached over axi4-lite
// assumes: one clock, synchronous active-high reset, pins asynchronous to the clock
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "kpi_defs.svh"

module kpi_pin_interrupt
	import kpi_pkg::*;
#(
	parameter int NUM_PINS = 4
)
(
	// clock and reset
	input wire logic CORE_CLK_IN,
	input wire logic SYS_RST_IN,
	// axi4-lite write address
	input wire logic [7:0] S_AXI_AWADDR_IN,
	input wire logic S_AXI_AWVALID_IN,
	output logic S_AXI_AWREADY_OUT,
	// axi4-lite write data
	input wire logic [31:0] S_AXI_WDATA_IN,
	input wire logic [3:0] S_AXI_WSTRB_IN,
	input wire logic S_AXI_WVALID_IN,
	output logic S_AXI_WREADY_OUT,
	// axi4-lite write response
	output logic [1:0] S_AXI_BRESP_OUT,
	output logic S_AXI_BVALID_OUT,
	input wire logic S_AXI_BREADY_IN,
	// axi4-lite read address
	input wire logic [7:0] S_AXI_ARADDR_IN,
	input wire logic S_AXI_ARVALID_IN,
	output logic S_AXI_ARREADY_OUT,
	// axi4-lite read data
	output logic [31:0] S_AXI_RDATA_OUT,
	output logic [1:0] S_AXI_RRESP_OUT,
	output logic S_AXI_RVALID_OUT,
	input wire logic S_AXI_RREADY_IN,
	// port a pins 3..0
	input wire logic [NUM_PINS-1:0] PORT_A_PINS_IN,
	// pin resistor controls
	output logic [NUM_PINS-1:0] PULL_UP_EN_OUT,
	output logic [NUM_PINS-1:0] PULL_DOWN_EN_OUT,
	// interrupt outputs
	output logic CPU_IRQ_OUT,
	output logic IRQ_OUT
);

	////////////////////////////////////////////////////////////////////////////
	// elaboration check

	if (NUM_PINS < 1 || NUM_PINS > 8)
	begin : g_bad_pins
		$error("NUM_PINS must be 1 to 8");
	end

	////////////////////////////////////////////////////////////////////////////
	// functions

	// byte address to register index, low two bits dropped; callers treat the address as unmapped if they are set
	function automatic logic [7:0] addr_to_idx(input logic [7:0] addr);
		addr_to_idx = {2'h0, addr[7:2]};
	endfunction

	// pins at their asserted level for the chosen polarity
	function automatic logic [NUM_PINS-1:0] asserted(input logic [NUM_PINS-1:0] pins,
		input logic [NUM_PINS-1:0] pol);
		asserted = ~(pins ^ pol);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// state

	logic [NUM_PINS-1:0] sync1_q, sync1_d;
	logic [NUM_PINS-1:0] sync2_q, sync2_d;
	logic [NUM_PINS-1:0] prev_q, prev_d;
	logic [NUM_PINS-1:0] armed_q, armed_d;
	logic flag_q, flag_d;
	logic reqen_q, reqen_d;
	logic mode_q, mode_d;
	logic [NUM_PINS-1:0] pin_en_q, pin_en_d;
	logic [NUM_PINS-1:0] pol_q, pol_d;
	logic [NUM_PINS-1:0] pull_en_q, pull_en_d;
	logic [1:0] irq_sts_q, irq_sts_d;
	logic [1:0] irq_mask_q, irq_mask_d;
	kpi_wr_e wr_q, wr_d;
	logic aw_got_q, aw_got_d;
	logic w_got_q, w_got_d;
	logic [7:0] aw_addr_q, aw_addr_d;
	logic [31:0] w_data_q, w_data_d;
	logic [3:0] w_strb_q, w_strb_d;
	logic [1:0] bresp_q, bresp_d;
	logic rvalid_q, rvalid_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0] rresp_q, rresp_d;

	// detection terms
	logic [NUM_PINS-1:0] lvl_now, edge_hit, level_hit;
	logic event_hit, any_asserted;
	// bus terms
	logic wr_fire, wr_en, ack_wr, wr_ok;
	logic [7:0] wr_idx, rd_idx;

	////////////////////////////////////////////////////////////////////////////
	// pin synchroniser and edge detection

	// two flip-flops before any logic reads the pins
	always_comb
	begin
		sync1_d = PORT_A_PINS_IN;
		sync2_d = sync1_q;
		prev_d = sync2_q;
	end

	// detection on the synchronised sample
	always_comb
	begin
		lvl_now = asserted(sync2_q, pol_q);
		// previous sample inactive, current active: rising or falling by polarity
		edge_hit = armed_q & ~asserted(prev_q, pol_q) & lvl_now & pin_en_q;
		level_hit = lvl_now & pin_en_q & {NUM_PINS{mode_q}};
		event_hit = |edge_hit | |level_hit;
		any_asserted = |(lvl_now & pin_en_q);
		// arm once an enabled pin has been seen inactive; disarm while disabled
		armed_d = (armed_q | ~lvl_now) & pin_en_q;
	end

	////////////////////////////////////////////////////////////////////////////
	// event flag

	// set wins over acknowledge; level mode blocks clear while asserted
	always_comb
	begin
		flag_d = flag_q & !(ack_wr && !(mode_q && any_asserted));
		flag_d = flag_d | event_hit;
	end

	// interrupt and pull outputs
	always_comb
	begin
		CPU_IRQ_OUT = flag_q & reqen_q;
		IRQ_OUT = |(irq_sts_q & irq_mask_q);
		PULL_UP_EN_OUT = pull_en_q & ~pol_q;
		PULL_DOWN_EN_OUT = pull_en_q & pol_q;
	end

	////////////////////////////////////////////////////////////////////////////
	// axi write channel

	always_comb
	begin
		wr_d = wr_q;
		aw_got_d = aw_got_q;
		w_got_d = w_got_q;
		aw_addr_d = aw_addr_q;
		w_data_d = w_data_q;
		w_strb_d = w_strb_q;
		bresp_d = bresp_q;
		wr_fire = 1'b0;
		S_AXI_AWREADY_OUT = 1'b0;
		S_AXI_WREADY_OUT = 1'b0;
		case (wr_q)
			KPI_WR_IDLE:
			begin
				S_AXI_AWREADY_OUT = !aw_got_q;
				S_AXI_WREADY_OUT = !w_got_q;
				if (S_AXI_AWVALID_IN && !aw_got_q)
				begin
					aw_got_d = 1'b1;
					aw_addr_d = S_AXI_AWADDR_IN;
				end
				if (S_AXI_WVALID_IN && !w_got_q)
				begin
					w_got_d = 1'b1;
					w_data_d = S_AXI_WDATA_IN;
					w_strb_d = S_AXI_WSTRB_IN;
				end
				if (aw_got_q && w_got_q)
				begin
					wr_fire = 1'b1;
					aw_got_d = 1'b0;
					w_got_d = 1'b0;
					bresp_d = wr_ok ? `KPI_RESP_OKAY : `KPI_RESP_SLVERR;
					wr_d = KPI_WR_RESP;
				end
			end
			KPI_WR_RESP:
			begin
				if (S_AXI_BREADY_IN)
				begin
					wr_d = KPI_WR_IDLE;
				end
			end
			default:
			begin
				wr_d = KPI_WR_IDLE;
			end
		endcase
		S_AXI_BVALID_OUT = (wr_q == KPI_WR_RESP);
		S_AXI_BRESP_OUT = bresp_q;
	end

	// write decode and register updates; only byte lane 0 carries data
	always_comb
	begin
		wr_idx = addr_to_idx(aw_addr_q);
		wr_en = wr_fire && w_strb_q[0];
		wr_ok = 1'b1;
		ack_wr = 1'b0;
		reqen_d = reqen_q;
		mode_d = mode_q;
		pin_en_d = pin_en_q;
		pol_d = pol_q;
		pull_en_d = pull_en_q;
		irq_mask_d = irq_mask_q;
		irq_sts_d = irq_sts_q;
		if (aw_addr_q[1:0] != 2'h0)
		begin
			wr_ok = 1'b0;
		end
		else if (wr_idx == `KPI_IDX_STATUS_CONTROL)
		begin
			// bits 7..4 and the flag bit are ignored on write
			ack_wr = wr_en && w_data_q[`KPI_SC_ACK_BIT];
			reqen_d = wr_en ? w_data_q[`KPI_SC_REQEN_BIT] : reqen_q;
			mode_d = wr_en ? w_data_q[`KPI_SC_MODE_BIT] : mode_q;
		end
		else if (wr_idx == `KPI_IDX_PIN_ENABLE)
		begin
			pin_en_d = wr_en ? w_data_q[NUM_PINS-1:0] : pin_en_q;
		end
		else if (wr_idx == `KPI_IDX_POLARITY)
		begin
			pol_d = wr_en ? w_data_q[NUM_PINS-1:0] : pol_q;
		end
		else if (wr_idx == `KPI_IDX_PULL_ENABLE)
		begin
			pull_en_d = wr_en ? w_data_q[NUM_PINS-1:0] : pull_en_q;
		end
		else if (wr_idx == `KPI_IDX_IRQ_MASK)
		begin
			irq_mask_d = wr_en ? w_data_q[1:0] : irq_mask_q;
		end
		else if (wr_idx == `KPI_IDX_IRQ_STATUS)
		begin
			irq_sts_d = wr_en ? (irq_sts_q & ~w_data_q[1:0]) : irq_sts_q;
		end
		else
		begin
			wr_ok = 1'b0;
		end
		// sticky events: bit 0 event detected, bit 1 flag cleared; set wins
		irq_sts_d[0] = irq_sts_d[0] | event_hit;
		irq_sts_d[1] = irq_sts_d[1] | (flag_q & ~flag_d);
	end

	////////////////////////////////////////////////////////////////////////////
	// axi read channel

	always_comb
	begin
		rd_idx = addr_to_idx(S_AXI_ARADDR_IN);
		S_AXI_ARREADY_OUT = !rvalid_q;
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (rvalid_q && S_AXI_RREADY_IN)
		begin
			rvalid_d = 1'b0;
		end
		if (S_AXI_ARVALID_IN && !rvalid_q)
		begin
			rvalid_d = 1'b1;
			rdata_d = 32'h0000_0000;
			rresp_d = `KPI_RESP_OKAY;
			if (S_AXI_ARADDR_IN[1:0] != 2'h0)
			begin
				rresp_d = `KPI_RESP_SLVERR;
			end
			else if (rd_idx == `KPI_IDX_STATUS_CONTROL)
			begin
				// upper nibble and acknowledge read zero
				rdata_d[`KPI_SC_FLAG_BIT] = flag_q;
				rdata_d[`KPI_SC_REQEN_BIT] = reqen_q;
				rdata_d[`KPI_SC_MODE_BIT] = mode_q;
			end
			else if (rd_idx == `KPI_IDX_PIN_ENABLE)
			begin
				rdata_d[NUM_PINS-1:0] = pin_en_q;
			end
			else if (rd_idx == `KPI_IDX_POLARITY)
			begin
				rdata_d[NUM_PINS-1:0] = pol_q;
			end
			else if (rd_idx == `KPI_IDX_PULL_ENABLE)
			begin
				rdata_d[NUM_PINS-1:0] = pull_en_q;
			end
			else if (rd_idx == `KPI_IDX_IRQ_STATUS)
			begin
				rdata_d[1:0] = irq_sts_q;
			end
			else if (rd_idx == `KPI_IDX_IRQ_MASK)
			begin
				rdata_d[1:0] = irq_mask_q;
			end
			else
			begin
				rresp_d = `KPI_RESP_SLVERR;
			end
		end
		S_AXI_RVALID_OUT = rvalid_q;
		S_AXI_RDATA_OUT = rdata_q;
		S_AXI_RRESP_OUT = rresp_q;
	end

	////////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge CORE_CLK_IN)
	begin
		if (SYS_RST_IN)
		begin
			sync1_q <= '0;
			sync2_q <= '0;
			prev_q <= '0;
			armed_q <= '0;
			flag_q <= 1'b0;
			reqen_q <= 1'b0;
			mode_q <= 1'b0;
			pin_en_q <= '0;
			pol_q <= '0;
			pull_en_q <= '0;
			irq_sts_q <= 2'h0;
			irq_mask_q <= 2'h0;
			wr_q <= KPI_WR_IDLE;
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			bresp_q <= 2'h0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= 2'h0;
		end
		else
		begin
			sync1_q <= sync1_d;
			sync2_q <= sync2_d;
			prev_q <= prev_d;
			armed_q <= armed_d;
			flag_q <= flag_d;
			reqen_q <= reqen_d;
			mode_q <= mode_d;
			pin_en_q <= pin_en_d;
			pol_q <= pol_d;
			pull_en_q <= pull_en_d;
			irq_sts_q <= irq_sts_d;
			irq_mask_q <= irq_mask_d;
			wr_q <= wr_d;
			aw_got_q <= aw_got_d;
			w_got_q <= w_got_d;
			aw_addr_q <= aw_addr_d;
			w_data_q <= w_data_d;
			w_strb_q <= w_strb_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end

endmodule

// >>> kpi_pin_interrupt_properties.sv
// assertions on the pin interrupt block ports
// assumes: bound to kpi_pin_interrupt from the bench top
`timescale 1ns/1ps
module kpi_pin_interrupt_properties
#(
	parameter int NUM_PINS = 4
)
(
	// clock and reset
	input wire logic CORE_CLK_IN,
	input wire logic SYS_RST_IN,
	// bus handshakes
	input wire logic S_AXI_ARVALID_IN,
	input wire logic S_AXI_ARREADY_OUT,
	input wire logic S_AXI_RVALID_OUT,
	input wire logic S_AXI_RREADY_IN,
	input wire logic S_AXI_BVALID_OUT,
	input wire logic S_AXI_BREADY_IN,
	// pulls and interrupts
	input wire logic [NUM_PINS-1:0] PULL_UP_EN_OUT,
	input wire logic [NUM_PINS-1:0] PULL_DOWN_EN_OUT,
	input wire logic CPU_IRQ_OUT,
	input wire logic IRQ_OUT
);
////////////////////////////////////////
	default clocking cb @(posedge CORE_CLK_IN);
	endclocking
	default disable iff (SYS_RST_IN);
	// read taken, write committed
	sequence rd_take;
		S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;
	endsequence
	sequence wr_commit;
		$rose(S_AXI_BVALID_OUT);
	endsequence
	rd_answer_a: assert property (rd_take |=> S_AXI_RVALID_OUT)
		else $error("no read answer");
	rd_cause_a: assert property ($rose(S_AXI_RVALID_OUT) |-> $past(S_AXI_ARVALID_IN))
		else $error("read answer unasked");
	ar_block_a: assert property (S_AXI_RVALID_OUT |-> !S_AXI_ARREADY_OUT)
		else $error("read taken early");
	r_hold_a: assert property (S_AXI_RVALID_OUT && !S_AXI_RREADY_IN |=> S_AXI_RVALID_OUT)
		else $error("read answer dropped");
	b_hold_a: assert property (S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=> S_AXI_BVALID_OUT)
		else $error("write answer dropped");
	pull_excl_a: assert property ((PULL_UP_EN_OUT & PULL_DOWN_EN_OUT) == '0)
		else $error("both pulls on");
	cpu_fall_a: assert property ($fell(CPU_IRQ_OUT) |-> wr_commit)
		else $error("request fell alone");
	irq_fall_a: assert property ($fell(IRQ_OUT) |-> wr_commit)
		else $error("interrupt fell alone");
endmodule

// >>> kpi_pin_source.sv
// switch model driving the four pins
// assumes: pins asynchronous to the core clock, idle high
`timescale 1ns/1ps
module kpi_pin_source
(
	// requested levels and settling speed
	input wire logic [3:0] level_in,
	input wire logic slow_in,
	// pins
	output logic [3:0] pins_out
);
	// pins follow after a short or long settling time
	initial
		pins_out = 4'hf;
	always @(level_in)
		pins_out <= #(slow_in ? 23.0 : 1.3) level_in;
endmodule

// >>> kpi_pin_interrupt_tb_top.sv
// bench: axi4-lite master tasks, pin source, scenarios
// assumes: package, design, checker, pin source compiled first
`timescale 1ns/1ps
module kpi_pin_interrupt_tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] awa = 8'h00, ara = 8'h00, wd = 8'h00;
	logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0, slow = 1'b0;
	logic awr, wrd, bv, arr, rv, cirq, irq;
	logic [1:0] br, rr, resp;
	logic [31:0] rdt, rdat;
	logic [3:0] lvl = 4'hf, pins, pu, pd;
	int num_errors = 0;
	int n_compared = 0;
////////////////////////////////////////
	// clock
	initial
		forever #2.5 clk = ~clk;
	// design and pins
	kpi_pin_interrupt dut
	(
		.CORE_CLK_IN(clk),
		.SYS_RST_IN(rst),
		.S_AXI_AWADDR_IN(awa),
		.S_AXI_AWVALID_IN(awv),
		.S_AXI_AWREADY_OUT(awr),
		.S_AXI_WDATA_IN({24'h0, wd}),
		.S_AXI_WSTRB_IN(4'h1),
		.S_AXI_WVALID_IN(wv),
		.S_AXI_WREADY_OUT(wrd),
		.S_AXI_BRESP_OUT(br),
		.S_AXI_BVALID_OUT(bv),
		.S_AXI_BREADY_IN(bre),
		.S_AXI_ARADDR_IN(ara),
		.S_AXI_ARVALID_IN(arv),
		.S_AXI_ARREADY_OUT(arr),
		.S_AXI_RDATA_OUT(rdt),
		.S_AXI_RRESP_OUT(rr),
		.S_AXI_RVALID_OUT(rv),
		.S_AXI_RREADY_IN(rre),
		.PORT_A_PINS_IN(pins),
		.PULL_UP_EN_OUT(pu),
		.PULL_DOWN_EN_OUT(pd),
		.CPU_IRQ_OUT(cirq),
		.IRQ_OUT(irq)
	);
	kpi_pin_source src
	(
		.level_in(lvl),
		.slow_in(slow),
		.pins_out(pins)
	);
////////////////////////////////////////
	// compare and verdict
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e)
		begin
			$display("MISMATCH %0t seen %h want %h", $time, s, e);
			num_errors++;
		end
	endtask
	task automatic summarize;
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic idle(input int k);
		repeat (k) @(negedge clk);
	endtask
	// bus write: valids and bready raised together, each dropped after its handshake edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		int n;
		logic ha, hw, hb;
		hb = 1'b0;
		@(posedge clk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bre <= 1'b1;
		for (n = 0; n < 40 && !hb; n++)
		begin
			@(negedge clk);
			ha = awv & awr;
			hw = wv & wrd;
			hb = bre & bv;
			resp = br;
			@(posedge clk);
			if (ha)
				awv <= 1'b0;
			if (hw)
				wv <= 1'b0;
			if (hb)
				bre <= 1'b0;
		end
		if (!hb)
		begin
			$display("MISMATCH %0t write timed out", $time);
			num_errors++;
			summarize();
		end
	endtask
	// bus read, same manner: rready held until rvalid is seen
	task automatic rd(input logic [7:0] a);
		int n;
		logic h, hr;
		hr = 1'b0;
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rre <= 1'b1;
		for (n = 0; n < 40 && !hr; n++)
		begin
			@(negedge clk);
			h = arv & arr;
			hr = rre & rv;
			rdat = rdt;
			resp = rr;
			@(posedge clk);
			if (h)
				arv <= 1'b0;
			if (hr)
				rre <= 1'b0;
		end
		if (!hr)
		begin
			$display("MISMATCH %0t read timed out", $time);
			num_errors++;
			summarize();
		end
	endtask
////////////////////////////////////////
	// reset value, read-only and write-only bits, unmapped read, pulls
	task automatic t_regs;
		rd(8'h30);
		chk(rdat, 32'h0);
		wr(8'h30, 8'hff);
		rd(8'h30);
		chk(rdat, 32'h3);
		wr(8'h30, 8'h00);
		rd(8'h3c);
		chk(32'(resp), 32'h2);
		wr(8'h3c, 8'h01);
		chk(32'(resp), 32'h2);
		wr(8'h48, 8'h0f);
		chk(32'(resp), 32'h0);
		wr(8'h38, 8'h05);
		chk(32'(pu), 32'ha);
		chk(32'(pd), 32'h5);
	endtask
	// every pin and polarity: disabled neighbour ignored, edge flags, ack
	task automatic t_edge;
		int p, i;
		logic [3:0] id;
		for (p = 0; p < 2; p++)
			for (i = 0; i < 4; i++)
			begin
				id = p ? 4'h0 : 4'hf;
				@(posedge clk);
				lvl <= id;
				wr(8'h30, 8'h00);
				wr(8'h38, {4'h0, ~id});
				wr(8'h34, 8'h01 << i);
				wr(8'h30, 8'h04);
				wr(8'h30, 8'h02);
				lvl <= id ^ (4'h1 << ((i + 1) % 4));
				idle(6);
				chk(32'(cirq), 32'h0);
				@(posedge clk);
				lvl <= id ^ (4'h1 << i);
				idle(6);
				chk(32'(cirq), 32'h1);
				wr(8'h30, 8'h06);
				idle(2);
				chk(32'(cirq), 32'h0);
			end
	endtask
	// pin asserted before enabling, then level mode against ack
	task automatic t_lvl;
		@(posedge clk);
		lvl <= 4'he;
		wr(8'h30, 8'h00);
		wr(8'h38, 8'h00);
		wr(8'h34, 8'h01);
		wr(8'h30, 8'h06);
		idle(6);
		chk(32'(cirq), 32'h0);
		wr(8'h30, 8'h03);
		idle(6);
		chk(32'(cirq), 32'h1);
		wr(8'h30, 8'h07);
		rd(8'h30);
		chk(rdat, 32'hb);
		wr(8'h30, 8'h01);
		chk(32'(cirq), 32'h0);
		slow <= 1'b1;
		lvl <= 4'hf;
		idle(12);
		wr(8'h30, 8'h07);
		rd(8'h30);
		chk(rdat, 32'h3);
	endtask
	// sticky status, mask, write-one clear
	task automatic t_irq;
		wr(8'h40, 8'h03);
		wr(8'h44, 8'h01);
		idle(2);
		chk(32'(irq), 32'h0);
		@(posedge clk);
		lvl <= 4'he;
		idle(8);
		@(posedge clk);
		lvl <= 4'hf;
		idle(8);
		chk(32'(irq), 32'h1);
		wr(8'h44, 8'h00);
		idle(2);
		chk(32'(irq), 32'h0);
		wr(8'h44, 8'h01);
		wr(8'h40, 8'h01);
		idle(2);
		chk(32'(irq), 32'h0);
	endtask
	// main sequence
	initial
	begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_edge();
		t_lvl();
		t_irq();
		summarize();
	end
endmodule
////////////////////////////////////////
bind kpi_pin_interrupt kpi_pin_interrupt_properties #(.NUM_PINS(NUM_PINS)) u_chk
(
	.CORE_CLK_IN(CORE_CLK_IN),
	.SYS_RST_IN(SYS_RST_IN),
	.S_AXI_ARVALID_IN(S_AXI_ARVALID_IN),
	.S_AXI_ARREADY_OUT(S_AXI_ARREADY_OUT),
	.S_AXI_RVALID_OUT(S_AXI_RVALID_OUT),
	.S_AXI_RREADY_IN(S_AXI_RREADY_IN),
	.S_AXI_BVALID_OUT(S_AXI_BVALID_OUT),
	.S_AXI_BREADY_IN(S_AXI_BREADY_IN),
	.PULL_UP_EN_OUT(PULL_UP_EN_OUT),
	.PULL_DOWN_EN_OUT(PULL_DOWN_EN_OUT),
	.CPU_IRQ_OUT(CPU_IRQ_OUT),
	.IRQ_OUT(IRQ_OUT)
);
